/* File: design/uart_mode_control.sv */
// Contract
// - enabled port owns pins chosen by usage field
// - disabled port leaves all pins to latches
// - halt bit stops port during idle
// - codec bit switches infrared encoder and decoder
// - infrared coding only with slow divider
// - usage code picks tx, rx, cts, rts, clock
// - wake bit: falling edge interrupts, rising clears
// - auto-rate measures sync byte, then clears
`timescale 1ns/100ps
`default_nettype none
`include "uart_mode_cfg.svh"
module uart_mode_control
#(
   parameter int ADDR_W = 8,
   parameter int CNT_W  = 16
)
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              idle_mode,
   input  wire logic              sleep_mode,
   input  wire logic              baud_tick16,
   input  wire logic              core_tx,
   input  wire logic              core_tx_busy,
   input  wire logic              core_rx_ready,
   input  wire logic              core_bclk,
   output logic                   core_rx,
   output logic                   core_cts_n,
   output logic                   core_run,
   output logic [15:0]            mode_bits,
   output logic [CNT_W-1:0]       rate_cycles,
   input  wire logic              latch_tx,
   input  wire logic              latch_tx_oe,
   input  wire logic              latch_rts,
   input  wire logic              latch_rts_oe,
   input  wire logic              serial_in_pin,
   input  wire logic              clear_send_pin,
   output logic                   serial_out_pin,
   output logic                   serial_out_oe,
   output logic                   req_send_pin,
   output logic                   req_send_oe,
   output logic                   irq
);
   logic [15:0]              serial_port_mode_reg;
   logic [1:0]               stat_reg;
   logic [1:0]               mask_reg;
   logic [ADDR_W-1:0]        awaddr_reg;
   logic [31:0]              wdata_reg;
   logic [3:0]               wstrb_reg;
   logic                     aw_held_reg;
   logic                     w_held_reg;
   logic                     rx_prev_reg;
   logic                     wake_fell_reg;
   logic                     do_write;
   logic                     do_read;
   logic                     rd_hit;
   logic [31:0]              rd_word;
   logic                     port_on;
   logic                     active;
   logic                     loop_on;
   logic                     owns_rts;
   logic                     rts_value;
   logic                     rx_line;
   logic                     wake_fall;
   logic                     wake_rise;
   logic                     ab_done;
   logic [CNT_W-1:0]         ab_cycles;
   uart_mode_pkg::pin_use_t  pin_usage_select;
   codec_if                  cif ();

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == `ADDR_MODE) || (a == `ADDR_STAT) ||
               (a == `ADDR_MASK) || (a == `ADDR_RATE);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   assign port_on          = serial_port_mode_reg[`BIT_ON];
   assign loop_on          = serial_port_mode_reg[`BIT_LOOP];
   assign pin_usage_select = uart_mode_pkg::pin_use_t'(
                                serial_port_mode_reg[`BIT_USE_HI:`BIT_USE_LO]);
   assign active   = port_on && !(serial_port_mode_reg[`BIT_IDLE] && idle_mode);
   assign core_run = active;
   assign mode_bits   = serial_port_mode_reg;
   assign rate_cycles = ab_cycles;

   // write channel: address and data may arrive in either order
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         awaddr_reg   <= '0;
         wdata_reg    <= 32'h0000_0000;
         wstrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read channel: one read at a time, data from a register
   assign s_axi_arready = !s_axi_rvalid;
   assign do_read       = s_axi_arvalid && s_axi_arready;
   assign rd_hit        = do_read && (s_axi_araddr == `ADDR_STAT);

   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         `ADDR_MODE: rd_word = {16'h0000, serial_port_mode_reg & `MODE_WMASK};
         `ADDR_STAT: rd_word = {30'h0, stat_reg};
         `ADDR_MASK: rd_word = {30'h0, mask_reg};
         `ADDR_RATE: rd_word = {{(32-CNT_W){1'b0}}, ab_cycles};
         default:    rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end
      else if (do_read)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // mode register: hardware clears wake and auto-rate, a same-cycle write wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         serial_port_mode_reg <= `MODE_RST;
      else if (do_write && awaddr_reg == `ADDR_MODE)
         serial_port_mode_reg <= merge16(serial_port_mode_reg, wdata_reg, wstrb_reg)
                                 & `MODE_WMASK;
      else
      begin
         if (wake_rise)
            serial_port_mode_reg[`BIT_WAKE] <= 1'b0;
         if (ab_done)
            serial_port_mode_reg[`BIT_AUTO_RATE_DETECT] <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask_reg <= 2'h0;
      else if (do_write && awaddr_reg == `ADDR_MASK && wstrb_reg[0])
         mask_reg <= wdata_reg[1:0];
   end

   // sticky events: a status read clears, an event in that same cycle survives
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         stat_reg <= `STAT_RST;
      else
      begin
         if (rd_hit)
            stat_reg <= `STAT_RST;
         if (wake_fall)
            stat_reg[`STAT_WAKE] <= 1'b1;
         if (ab_done)
            stat_reg[`STAT_ABD] <= 1'b1;
      end
   end

   assign irq = |(stat_reg & mask_reg);

   // wake on start bit while sleeping
   assign wake_fall = serial_port_mode_reg[`BIT_WAKE] && sleep_mode &&
                      rx_prev_reg && !serial_in_pin;
   assign wake_rise = serial_port_mode_reg[`BIT_WAKE] && wake_fell_reg &&
                      !rx_prev_reg && serial_in_pin;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_prev_reg   <= 1'b1;
         wake_fell_reg <= 1'b0;
      end
      else
      begin
         rx_prev_reg <= serial_in_pin;
         if (wake_fall)
            wake_fell_reg <= 1'b1;
         else if (!serial_port_mode_reg[`BIT_WAKE])
            wake_fell_reg <= 1'b0;
      end
   end

   // infrared coder, bypassed when off or with the fast divider
   assign cif.enable   = serial_port_mode_reg[`BIT_IR] &&
                         !serial_port_mode_reg[`BIT_FAST] && active;
   assign cif.tick16   = baud_tick16;
   assign cif.tx_plain = core_tx;
   assign cif.rx_coded = serial_in_pin;

   ir_codec u_ir_codec
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cif     (cif.codec)
   );

   // receiver input: transmit looped back internally in loopback mode
   always_comb
   begin
      if (loop_on)
         rx_line = core_tx;
      else if (cif.enable)
         rx_line = cif.rx_plain;
      else
         rx_line = serial_in_pin;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         core_rx <= 1'b1;
      else
         core_rx <= active ? rx_line : 1'b1;
   end

   rate_meter #(.CNT_W(CNT_W)) u_rate_meter
   (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .arm        (serial_port_mode_reg[`BIT_AUTO_RATE_DETECT] && active),
      .rx         (rx_line),
      .done       (ab_done),
      .bit_cycles (ab_cycles)
   );

   // pin ownership
   assign owns_rts = port_on && pin_usage_select != uart_mode_pkg::use_txrx;

   always_comb
   begin
      if (pin_usage_select == uart_mode_pkg::use_txrx_bclk)
         rts_value = core_bclk;
      else if (serial_port_mode_reg[`BIT_REQ_SEND_PIN_MODE])
         rts_value = !core_tx_busy;
      else
         rts_value = !core_rx_ready;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         serial_out_pin <= 1'b1;
         serial_out_oe  <= 1'b0;
         req_send_pin   <= 1'b1;
         req_send_oe    <= 1'b0;
         core_cts_n     <= 1'b1;
      end
      else
      begin
         if (port_on)
         begin
            serial_out_oe  <= 1'b1;
            serial_out_pin <= loop_on ? 1'b1 :
                              (cif.enable ? cif.tx_coded : core_tx);
         end
         else
         begin
            serial_out_oe  <= latch_tx_oe;
            serial_out_pin <= latch_tx;
         end
         if (owns_rts)
         begin
            req_send_oe  <= 1'b1;
            req_send_pin <= rts_value;
         end
         else
         begin
            req_send_oe  <= latch_rts_oe;
            req_send_pin <= latch_rts;
         end
         core_cts_n <= (port_on && pin_usage_select == uart_mode_pkg::use_txrx_flow)
                       ? clear_send_pin : 1'b0;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_sleep_fall;
      serial_port_mode_reg[`BIT_WAKE] && sleep_mode && rx_prev_reg && !serial_in_pin;
   endsequence

   sequence s_next_rise;
      ##[1:1000] (rx_prev_reg == 1'b0 && serial_in_pin == 1'b1);
   endsequence

   property p_off_latch;
      aresetn && !port_on
         |=> (serial_out_pin == $past(latch_tx)) && (req_send_oe == $past(latch_rts_oe));
   endproperty
   a_off_latch: assert property (p_off_latch) else $error("latch lost pins");

   property p_on_owns;
      port_on |=> serial_out_oe;
   endproperty
   a_on_owns: assert property (p_on_owns) else $error("port not driving tx");

   property p_txrx_only;
      port_on && pin_usage_select == uart_mode_pkg::use_txrx
         |=> req_send_pin == $past(latch_rts);
   endproperty
   a_txrx_only: assert property (p_txrx_only) else $error("rts not latch");

   property p_idle_halt;
      port_on && serial_port_mode_reg[`BIT_IDLE] && idle_mode |-> !core_run;
   endproperty
   a_idle_halt: assert property (p_idle_halt) else $error("runs in idle");

   property p_ir_slow;
      serial_port_mode_reg[`BIT_FAST] |-> !cif.enable;
   endproperty
   a_ir_slow: assert property (p_ir_slow) else $error("ir with fast div");

   property p_loop;
      active && loop_on |=> core_rx == $past(core_tx);
   endproperty
   a_loop: assert property (p_loop) else $error("loopback broken");

   property p_wake_irq;
      s_sleep_fall ##0 !rd_hit |=> stat_reg[`STAT_WAKE];
   endproperty
   a_wake_irq: assert property (p_wake_irq) else $error("wake lost");

   property p_wake_clear;
      s_sleep_fall ##1 (!do_write throughout s_next_rise) |=> !serial_port_mode_reg[`BIT_WAKE];
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("wake not cleared");

   property p_auto_rate_detect_clear;
      ab_done && !do_write |=> !serial_port_mode_reg[`BIT_AUTO_RATE_DETECT] && stat_reg[`STAT_ABD];
   endproperty
   a_auto_rate_detect_clear: assert property (p_auto_rate_detect_clear) else $error("auto_rate_detect stuck");

   property p_unused_zero;
      s_axi_rvalid && $past(do_read && s_axi_araddr == `ADDR_MODE)
         |-> s_axi_rdata[14] == 1'b0 && s_axi_rdata[10] == 1'b0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("reserved set");
endmodule
`default_nettype wire

/* File: common/uart_mode_cfg.svh */
`ifndef UART_MODE_CFG_SVH
`define UART_MODE_CFG_SVH
`define ADDR_MODE      8'h00
`define ADDR_STAT      8'h04
`define ADDR_MASK      8'h08
`define ADDR_RATE      8'h0C
`define BIT_ON         15
`define BIT_IDLE       13
`define BIT_IR         12
`define BIT_REQ_SEND_PIN_MODE      11
`define BIT_USE_HI     9
`define BIT_USE_LO     8
`define BIT_WAKE       7
`define BIT_LOOP       6
`define BIT_AUTO_RATE_DETECT      5
`define BIT_FAST       3
`define MODE_WMASK     16'hBBFF
`define MODE_RST       16'h0000
`define STAT_WAKE      0
`define STAT_ABD       1
`define STAT_RST       2'h0
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define AB_FALLS       3'h5
`define AB_SHIFT       3
`define IR_PULSE       4'h3
`endif

/* File: common/uart_mode_pkg.sv */
`default_nettype none
package uart_mode_pkg;
   typedef enum logic [1:0]
   {
      use_txrx      = 2'b00,
      use_txrx_rts  = 2'b01,
      use_txrx_flow = 2'b10,
      use_txrx_bclk = 2'b11
   } pin_use_t;
   typedef enum logic [1:0]
   {
      ab_idle  = 2'b00,
      ab_start = 2'b01,
      ab_count = 2'b10
   } ab_state_t;
endpackage
`default_nettype wire

/* File: common/codec_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface codec_if;
   logic enable;
   logic tick16;
   logic tx_plain;
   logic tx_coded;
   logic rx_coded;
   logic rx_plain;
   modport codec (input enable, tick16, tx_plain, rx_coded, output tx_coded, rx_plain);
   modport user  (output enable, tick16, tx_plain, rx_coded, input tx_coded, rx_plain);
endinterface
`default_nettype wire

/* File: design/ir_codec.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uart_mode_cfg.svh"
module ir_codec
(
   input  wire logic aclk,
   input  wire logic aresetn,
   codec_if.codec    cif
);
   logic [3:0] tx_phase_reg;
   logic [3:0] rx_hold_reg;
   logic       tx_coded_reg;

   // encoder: a short high pulse in each zero bit, line idles low
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tx_phase_reg <= 4'h0;
      else if (cif.tick16)
         tx_phase_reg <= tx_phase_reg + 4'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tx_coded_reg <= 1'b0;
      else
         tx_coded_reg <= cif.enable && !cif.tx_plain && (tx_phase_reg < `IR_PULSE);
   end

   // decoder: a received pulse is stretched to a whole zero bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rx_hold_reg <= 4'h0;
      else if (cif.enable && cif.rx_coded)
         rx_hold_reg <= 4'hF;
      else if (cif.tick16 && rx_hold_reg != 4'h0)
         rx_hold_reg <= rx_hold_reg - 4'h1;
   end

   assign cif.tx_coded = tx_coded_reg;
   assign cif.rx_plain = (rx_hold_reg == 4'h0);
endmodule
`default_nettype wire

/* File: design/rate_meter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uart_mode_cfg.svh"
module rate_meter
#(
   parameter int CNT_W = 16
)
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             arm,
   input  wire logic             rx,
   output logic                  done,
   output logic [CNT_W-1:0]      bit_cycles
);
   uart_mode_pkg::ab_state_t state_reg;
   logic [CNT_W+2:0] span_reg;
   logic [2:0]       falls_reg;
   logic             rx_prev_reg;
   logic             fall;

   assign fall = rx_prev_reg && !rx;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rx_prev_reg <= 1'b1;
      else
         rx_prev_reg <= rx;
   end

   // the sync byte spans eight bit times between its first and fifth falling edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg  <= uart_mode_pkg::ab_idle;
         span_reg   <= '0;
         falls_reg  <= 3'h0;
         done       <= 1'b0;
         bit_cycles <= '0;
      end
      else
      begin
         done <= 1'b0;
         case (state_reg)
            uart_mode_pkg::ab_idle:
               if (arm)
                  state_reg <= uart_mode_pkg::ab_start;
            uart_mode_pkg::ab_start:
               if (!arm)
                  state_reg <= uart_mode_pkg::ab_idle;
               else if (fall)
               begin
                  state_reg <= uart_mode_pkg::ab_count;
                  // start at one so the span covers the cycle of the first fall
                  span_reg  <= (CNT_W+3)'(1);
                  falls_reg <= 3'h1;
               end
            uart_mode_pkg::ab_count:
               if (!arm)
                  state_reg <= uart_mode_pkg::ab_idle;
               else if (fall && falls_reg == `AB_FALLS - 3'h1)
               begin
                  state_reg  <= uart_mode_pkg::ab_idle;
                  done       <= 1'b1;
                  bit_cycles <= span_reg[CNT_W+2:`AB_SHIFT];
               end
               else
               begin
                  span_reg <= span_reg + 1'b1;
                  if (fall)
                     falls_reg <= falls_reg + 3'h1;
               end
            default:
               state_reg <= uart_mode_pkg::ab_idle;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: testbench/serial_peer.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_peer
#(
   parameter int BIT_CYC = 16
)
(
   input  wire logic clk,
   output logic      line,
   output logic      cts
);
   initial
   begin
      line = 1'h1;
      cts  = 1'h0;
   end
   task automatic hold_bit(input logic b);
      line <= b;
      repeat (BIT_CYC) @(posedge clk);
   endtask
   // frame: start low, data lsb first, stop high; caller sends the sync byte first
   task automatic send_byte(input logic [7:0] b);
      cts <= 1'($urandom);
      hold_bit(1'h0);
      for (int i = 0; i < 8; i++)
         hold_bit(b[i]);
      hold_bit(1'h1);
   endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int BIT_CYC = 16;
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        idle_mode = 1'h0, sleep_mode = 1'h0, baud_tick16 = 1'h0, core_tx = 1'h1;
   logic        core_tx_busy = 1'h0, core_rx_ready = 1'h0, core_bclk = 1'h0;
   logic        latch_tx = 1'h0, latch_tx_oe = 1'h0, latch_rts = 1'h0, latch_rts_oe = 1'h0;
   logic        serial_in_pin, clear_send_pin, core_rx, core_cts_n, core_run, irq;
   logic        serial_out_pin, serial_out_oe, req_send_pin, req_send_oe, act;
   logic [15:0] mode_bits, rate_cycles, m;
   int          num_errors = 0, samples_checked = 0;

   always #50 aclk = ~aclk;
   always @(posedge aclk)
      baud_tick16 <= ($urandom % 16) == 0;

   uart_mode_control i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .idle_mode, .sleep_mode, .baud_tick16, .core_tx,
      .core_tx_busy, .core_rx_ready, .core_bclk, .core_rx, .core_cts_n, .core_run, .mode_bits,
      .rate_cycles, .latch_tx, .latch_tx_oe, .latch_rts, .latch_rts_oe, .serial_in_pin,
      .clear_send_pin, .serial_out_pin, .serial_out_oe, .req_send_pin, .req_send_oe, .irq);
   serial_peer #(.BIT_CYC(BIT_CYC)) i_peer (.clk(aclk), .line(serial_in_pin),
      .cts(clear_send_pin));

   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      fork
         begin
            do @(posedge aclk); while (!s_axi_awready);
            s_axi_awvalid <= 1'h0;
         end
         begin
            do @(posedge aclk); while (!s_axi_wready);
            s_axi_wvalid <= 1'h0;
         end
      join
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, r);
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask

   // expected {serial_out_pin, serial_out_oe, req_send_pin, req_send_oe}
   function automatic logic [3:0] exp_pins(input logic [15:0] mv);
      logic rq;
      rq = mv[11] ? !core_tx_busy : !core_rx_ready;
      if (!mv[15])
         return {latch_tx, latch_tx_oe, latch_rts, latch_rts_oe};
      case (mv[9:8])
         2'h0: return {mv[6] | core_tx, 1'h1, latch_rts, latch_rts_oe};
         2'h3: return {mv[6] | core_tx, 1'h1, core_bclk, 1'h1};
         default: return {mv[6] | core_tx, 1'h1, rq, 1'h1};
      endcase
   endfunction

   initial
   begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      report_and_stop;
   end

   initial
   begin
      void'($urandom(32'h8C05D202));
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd_reg(8'h00);
      chk(rd, 32'h0);
      rd_reg(8'h10);
      chk(rs, 2'h2);
      chk(rd, 32'h0);
      wr(8'h10, 32'h1, 2'h2);
      wr(8'h00, 32'hFFFF, 2'h0);
      rd_reg(8'h00);
      chk(rd, 32'hBBFF);
      for (int i = 0; i < 40; i++)
      begin
         m = 16'($urandom) & 16'hAB40;
         {idle_mode, latch_tx, latch_tx_oe, latch_rts, latch_rts_oe} <= 5'($urandom);
         {core_tx, core_tx_busy, core_rx_ready, core_bclk} <= 4'($urandom);
         i_peer.cts <= 1'($urandom);
         wr(8'h00, {16'h0, m}, 2'h0);
         repeat (2) @(posedge aclk);
         act = m[15] & !(m[13] & idle_mode);
         chk(mode_bits, m);
         chk(core_run, act);
         chk({serial_out_pin, serial_out_oe, req_send_pin, req_send_oe},
             exp_pins(m));
         chk(core_rx, (act && m[6]) ? core_tx : 1'h1);
         chk(core_cts_n, (m[15] && m[9:8] == 2'h2) ? clear_send_pin : 1'h0);
      end
      // infrared encoder idles low; the fast divider bypasses it
      idle_mode <= 1'h0;
      core_tx   <= 1'h1;
      wr(8'h00, 32'h9000, 2'h0);
      repeat (3) @(posedge aclk);
      chk(serial_out_pin, 1'h0);
      wr(8'h00, 32'h9008, 2'h0);
      repeat (2) @(posedge aclk);
      chk(serial_out_pin, 1'h1);
      wr(8'h08, 32'h3, 2'h0);
      wr(8'h00, 32'h8020, 2'h0);
      i_peer.send_byte(8'h55);
      rd_reg(8'h00);
      chk(rd, 32'h8000);
      chk(irq, 1'h1);
      rd_reg(8'h0C);
      chk(rd, BIT_CYC);
      chk(rate_cycles, BIT_CYC);
      rd_reg(8'h04);
      chk(rd, 32'h2);
      rd_reg(8'h04);
      chk(rd, 32'h0);
      chk(irq, 1'h0);
      wr(8'h08, 32'h0, 2'h0);
      sleep_mode <= 1'h1;
      wr(8'h00, 32'h8080, 2'h0);
      i_peer.hold_bit(1'h0);
      chk(irq, 1'h0);
      i_peer.hold_bit(1'h1);
      sleep_mode <= 1'h0;
      wr(8'h08, 32'h1, 2'h0);
      chk(irq, 1'h1);
      rd_reg(8'h00);
      chk(rd, 32'h8000);
      rd_reg(8'h04);
      chk(rd, 32'h1);
      chk(irq, 1'h0);
      report_and_stop;
   end
endmodule
`default_nettype wire
